// ===== rxhf_defs.svh
// Register offsets, field layout, reset values and counts for the receive header filter
`ifndef RXHF_DEFS_SVH
`define RXHF_DEFS_SVH
`define RXHF_OFS_FIFO_CNT  8'h00
`define RXHF_OFS_FIFO_POP  8'h04
`define RXHF_OFS_END_WORD  8'h08
`define RXHF_OFS_RD_ADDR   8'h0C
`define RXHF_OFS_RD_DATA   8'h10
`define RXHF_OFS_IRQ_STAT  8'h14
`define RXHF_OFS_IRQ_CLR   8'h18
`define RXHF_OFS_IRQ_EN    8'h1C
`define RXHF_OFS_MASK_LO   8'h20
`define RXHF_OFS_MASK_HI   8'h24
`define RXHF_OFS_END_POS   8'h28
`define RXHF_OFS_HDR_BASE  8'h40
`define RXHF_HDR_WORDS     4'hA
`define RXHF_HDR_BYTES     6'h26
`define RXHF_HDR_BEATS     3'h5
`define RXHF_IRQ_ACCEPT    0
`define RXHF_IRQ_REJECT    1
`define RXHF_IRQ_OVERFLOW  2
`define RXHF_RST_IRQ_EN    3'h0
`define RXHF_RST_MASK      38'h0
`define RXHF_RESP_OKAY     2'h0
`define RXHF_RESP_SLVERR   2'h2
`endif

// ===== rxhf_pkg.sv
// Types shared by the receive header filter modules
package rxhf_pkg;
    typedef struct packed {
        logic        valid;
        logic        last;
        logic [63:0] data;
    } rxhf_beat_t;

    typedef enum logic [2:0] {
        RXHF_IDLE = 3'b001,
        RXHF_HDR  = 3'b010,
        RXHF_BODY = 3'b100
    } rxhf_state_t;
endpackage : rxhf_pkg

// ===== rxhf_byte_cmp.sv
// Per-lane byte comparator used by the header filter
`timescale 1ns/1ps
`default_nettype none
module rxhf_byte_cmp #(
    parameter int LANES = 8
) (
    input  wire logic [LANES*8-1:0] data_i,
    input  wire logic [LANES*8-1:0] expect_i,
    input  wire logic [LANES-1:0]   enable_i,
    output logic      [LANES-1:0]   match_o
);
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        // A lane that is not enabled always counts as matching
        assign match_o[g] = !enable_i[g] || (data_i[g*8 +: 8] == expect_i[g*8 +: 8]);
    end
endmodule : rxhf_byte_cmp
`default_nettype wire

// ===== rxhf_top.sv
// Receive packet header filter and buffer with AXI4-Lite register access
//
// Operation
// - Compare header over five beats, eight bytes each
// - Write address starts at accepted end position
// - Every valid beat written into receive RAM
// - Bytes zero to thirty-seven reach the comparator
// - Mask bit per byte; disabled bytes match
// - All matched on last with FIFO room: push, latch end
// - Mismatch keeps end position; packet overwritten
// - FIFO of end addresses, count readable
// - 64-bit stream in, 32-bit RAM-style reads
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rxhf_defs.svh"
module rxhf_top #(
    parameter int RAM_AW  = 9,
    parameter int FIFO_AW = 4
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rstn_i,
    input  wire rxhf_pkg::rxhf_beat_t     mac_rx_beat_i,
    input  wire logic [7:0]               s_axi_awaddr_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    output logic [1:0]                    s_axi_bresp_o,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    input  wire logic [7:0]               s_axi_araddr_i,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    output logic                          irq_o
);
    localparam int FIFO_D = 1 << FIFO_AW;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [63:0]       receive_packet_ram [0:(1<<RAM_AW)-1];
    logic [RAM_AW-1:0] end_fifo_mem       [0:FIFO_D-1];

    // ------------------------------------------------------------------
    // Stream side state
    // ------------------------------------------------------------------
    rxhf_pkg::rxhf_state_t st_r, st_nxt;
    logic [2:0]            hdr_idx_r, hdr_idx_nxt;
    logic [RAM_AW-1:0]     rx_ram_write_address_r, rx_ram_write_address_nxt;
    logic [RAM_AW-1:0]     accepted_end_position_latch_r, accepted_end_position_latch_nxt;
    logic [39:0]           header_byte_match_flags_r, header_byte_match_flags_nxt;
    logic                  end_address_valid_pulse_r, end_address_valid_pulse_nxt;
    logic [RAM_AW-1:0]     end_push_word_r, end_push_word_nxt;

    // ------------------------------------------------------------------
    // Register side state
    // ------------------------------------------------------------------
    logic                  aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0]            aw_addr_r, aw_addr_nxt;
    logic [31:0]           w_data_r, w_data_nxt;
    logic [3:0]            w_strb_r, w_strb_nxt;
    logic                  bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
    logic [1:0]            bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]           rdata_r, rdata_nxt;
    logic [37:0]           header_byte_compare_mask_r, header_byte_compare_mask_nxt;
    logic [319:0]          expected_header_value_r, expected_header_value_nxt;
    logic [RAM_AW:0]       rx_ram_read_address_r, rx_ram_read_address_nxt;
    logic [RAM_AW-1:0]     end_address_fifo_word_r, end_address_fifo_word_nxt;
    logic [FIFO_AW:0]      fifo_wp_r, fifo_wp_nxt, fifo_rp_r, fifo_rp_nxt;
    logic [2:0]            irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt;
    logic                  irq_r, irq_nxt;

    // ------------------------------------------------------------------
    // Header compare and packet acceptance
    // ------------------------------------------------------------------
    logic              first_beat, hdr_active, pkt_end, accept;
    logic [2:0]        hdr_sel;
    logic [7:0]        lane_match;
    logic [39:0]       mask_full, flags_upd;
    logic [RAM_AW-1:0] cur_addr, end_addr;
    logic [FIFO_AW:0]  end_address_fifo_count, fifo_load;
    logic              end_address_fifo_pop;

    assign mask_full  = {2'b00, header_byte_compare_mask_r};
    assign first_beat = mac_rx_beat_i.valid && (st_r == rxhf_pkg::RXHF_IDLE);
    assign hdr_active = mac_rx_beat_i.valid && (st_r != rxhf_pkg::RXHF_BODY);
    assign hdr_sel    = first_beat ? 3'h0 : hdr_idx_r;

    rxhf_byte_cmp #(
        .LANES    (8)
    ) header_comparator (
        .data_i   (mac_rx_beat_i.data),
        .expect_i (expected_header_value_r[{hdr_sel, 6'h00} +: 64]),
        .enable_i (mask_full[{hdr_sel, 3'h0} +: 8]),
        .match_o  (lane_match)
    );

    assign end_address_fifo_count = fifo_wp_r - fifo_rp_r;
    assign fifo_load = end_address_fifo_count + {{FIFO_AW{1'b0}}, end_address_valid_pulse_r};

    always_comb begin
        st_nxt                          = st_r;
        hdr_idx_nxt                     = hdr_idx_r;
        cur_addr                        = first_beat ? accepted_end_position_latch_r
                                                     : rx_ram_write_address_r;
        end_addr                        = cur_addr + 1'b1;
        flags_upd                       = first_beat ? ~mask_full : header_byte_match_flags_r;
        if (hdr_active) begin
            flags_upd[{hdr_sel, 3'h0} +: 8] = lane_match;
        end
        pkt_end                         = mac_rx_beat_i.valid && mac_rx_beat_i.last;
        // The FIFO must have room, otherwise the end position could not be reported
        accept                          = pkt_end && (&flags_upd)
                                          && (fifo_load < FIFO_D[FIFO_AW:0]);
        rx_ram_write_address_nxt        = mac_rx_beat_i.valid ? end_addr
                                                              : rx_ram_write_address_r;
        accepted_end_position_latch_nxt = accept ? end_addr
                                                 : accepted_end_position_latch_r;
        end_address_valid_pulse_nxt     = accept;
        end_push_word_nxt               = accept ? end_addr : end_push_word_r;
        header_byte_match_flags_nxt     = mac_rx_beat_i.valid ? flags_upd
                                                              : header_byte_match_flags_r;
        case (st_r)
            rxhf_pkg::RXHF_IDLE: begin
                if (mac_rx_beat_i.valid && !mac_rx_beat_i.last) begin
                    st_nxt      = rxhf_pkg::RXHF_HDR;
                    hdr_idx_nxt = 3'h1;
                end
            end
            rxhf_pkg::RXHF_HDR: begin
                if (pkt_end) begin
                    st_nxt = rxhf_pkg::RXHF_IDLE;
                end else if (mac_rx_beat_i.valid) begin
                    hdr_idx_nxt = hdr_idx_r + 3'h1;
                    if (hdr_idx_r == `RXHF_HDR_BEATS - 3'h1) begin
                        st_nxt = rxhf_pkg::RXHF_BODY;
                    end
                end
            end
            rxhf_pkg::RXHF_BODY: begin
                if (pkt_end) begin
                    st_nxt = rxhf_pkg::RXHF_IDLE;
                end
            end
            default: begin
                st_nxt = rxhf_pkg::RXHF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            st_r                          <= rxhf_pkg::RXHF_IDLE;
            hdr_idx_r                     <= 3'h0;
            rx_ram_write_address_r        <= '0;
            accepted_end_position_latch_r <= '0;
            header_byte_match_flags_r     <= 40'h0;
            end_address_valid_pulse_r     <= 1'b0;
            end_push_word_r               <= '0;
        end else begin
            st_r                          <= st_nxt;
            hdr_idx_r                     <= hdr_idx_nxt;
            rx_ram_write_address_r        <= rx_ram_write_address_nxt;
            accepted_end_position_latch_r <= accepted_end_position_latch_nxt;
            header_byte_match_flags_r     <= header_byte_match_flags_nxt;
            end_address_valid_pulse_r     <= end_address_valid_pulse_nxt;
            end_push_word_r               <= end_push_word_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (mac_rx_beat_i.valid) begin
            receive_packet_ram[cur_addr] <= mac_rx_beat_i.data;
        end
        if (end_address_valid_pulse_r) begin
            end_fifo_mem[fifo_wp_r[FIFO_AW-1:0]] <= end_push_word_r;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave and registers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rxhf_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : rxhf_strb

    logic        do_wr, do_rd;
    logic [63:0] ram_rd_word;
    logic [31:0] old_v, new_v;
    logic [3:0]  hdr_w_idx, hdr_r_idx;

    assign ram_rd_word = receive_packet_ram[rx_ram_read_address_r[RAM_AW:1]];
    assign hdr_w_idx   = aw_addr_r[5:2];
    assign hdr_r_idx   = s_axi_araddr_i[5:2];

    always_comb begin
        aw_got_nxt                   = aw_got_r;
        w_got_nxt                    = w_got_r;
        aw_addr_nxt                  = aw_addr_r;
        w_data_nxt                   = w_data_r;
        w_strb_nxt                   = w_strb_r;
        bvalid_nxt                   = bvalid_r;
        bresp_nxt                    = bresp_r;
        rvalid_nxt                   = rvalid_r;
        rresp_nxt                    = rresp_r;
        rdata_nxt                    = rdata_r;
        arready_nxt                  = arready_r;
        header_byte_compare_mask_nxt = header_byte_compare_mask_r;
        expected_header_value_nxt    = expected_header_value_r;
        rx_ram_read_address_nxt      = rx_ram_read_address_r;
        end_address_fifo_word_nxt    = end_address_fifo_word_r;
        irq_en_nxt                   = irq_en_r;
        end_address_fifo_pop         = 1'b0;
        old_v                        = 32'h0;
        new_v                        = 32'h0;
        if (s_axi_awvalid_i && !aw_got_r) begin
            aw_got_nxt  = 1'b1;
            aw_addr_nxt = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_got_r) begin
            w_got_nxt  = 1'b1;
            w_data_nxt = s_axi_wdata_i;
            w_strb_nxt = s_axi_wstrb_i;
        end
        do_wr = aw_got_r && w_got_r && !bvalid_r;
        if (do_wr) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = `RXHF_RESP_OKAY;
            if (aw_addr_r >= `RXHF_OFS_HDR_BASE && hdr_w_idx < `RXHF_HDR_WORDS
                && aw_addr_r[7:6] == 2'b01) begin
                old_v = expected_header_value_r[{hdr_w_idx, 5'h00} +: 32];
                expected_header_value_nxt[{hdr_w_idx, 5'h00} +: 32] =
                    rxhf_strb(old_v, w_data_r, w_strb_r);
            end else begin
                case (aw_addr_r)
                    `RXHF_OFS_FIFO_POP: begin
                        // Popping an empty FIFO is ignored and leaves the word unchanged
                        end_address_fifo_pop = (end_address_fifo_count != '0);
                        if (end_address_fifo_pop) begin
                            end_address_fifo_word_nxt = end_fifo_mem[fifo_rp_r[FIFO_AW-1:0]];
                        end
                    end
                    `RXHF_OFS_RD_ADDR: begin
                        new_v = rxhf_strb({{(31-RAM_AW){1'b0}}, rx_ram_read_address_r},
                                          w_data_r, w_strb_r);
                        rx_ram_read_address_nxt = new_v[RAM_AW:0];
                    end
                    `RXHF_OFS_IRQ_CLR: begin
                    end
                    `RXHF_OFS_IRQ_EN: begin
                        new_v = rxhf_strb({29'h0, irq_en_r}, w_data_r, w_strb_r);
                        irq_en_nxt = new_v[2:0];
                    end
                    `RXHF_OFS_MASK_LO: begin
                        header_byte_compare_mask_nxt[31:0] =
                            rxhf_strb(header_byte_compare_mask_r[31:0], w_data_r, w_strb_r);
                    end
                    `RXHF_OFS_MASK_HI: begin
                        new_v = rxhf_strb({26'h0, header_byte_compare_mask_r[37:32]},
                                          w_data_r, w_strb_r);
                        header_byte_compare_mask_nxt[37:32] = new_v[5:0];
                    end
                    default: begin
                        bresp_nxt = `RXHF_RESP_SLVERR;
                    end
                endcase
            end
        end
        if (bvalid_r && s_axi_bready_i) begin
            bvalid_nxt = 1'b0;
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
        end
        do_rd = s_axi_arvalid_i && arready_r;
        if (do_rd) begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rresp_nxt   = `RXHF_RESP_OKAY;
            rdata_nxt   = 32'h0;
            if (s_axi_araddr_i >= `RXHF_OFS_HDR_BASE && hdr_r_idx < `RXHF_HDR_WORDS
                && s_axi_araddr_i[7:6] == 2'b01) begin
                rdata_nxt = expected_header_value_r[{hdr_r_idx, 5'h00} +: 32];
            end else begin
                case (s_axi_araddr_i)
                    `RXHF_OFS_FIFO_CNT: rdata_nxt[FIFO_AW:0]  = end_address_fifo_count;
                    `RXHF_OFS_END_WORD: rdata_nxt[RAM_AW-1:0] = end_address_fifo_word_r;
                    `RXHF_OFS_RD_ADDR:  rdata_nxt[RAM_AW:0]   = rx_ram_read_address_r;
                    // Even 32-bit address holds the low half of the stored beat
                    `RXHF_OFS_RD_DATA:  rdata_nxt = rx_ram_read_address_r[0] ? ram_rd_word[63:32]
                                                                              : ram_rd_word[31:0];
                    `RXHF_OFS_IRQ_STAT: rdata_nxt[2:0]        = irq_stat_r;
                    `RXHF_OFS_IRQ_EN:   rdata_nxt[2:0]        = irq_en_r;
                    `RXHF_OFS_MASK_LO:  rdata_nxt             = header_byte_compare_mask_r[31:0];
                    `RXHF_OFS_MASK_HI:  rdata_nxt[5:0]        = header_byte_compare_mask_r[37:32];
                    `RXHF_OFS_END_POS:  rdata_nxt[RAM_AW-1:0] = accepted_end_position_latch_r;
                    default:            rresp_nxt             = `RXHF_RESP_SLVERR;
                endcase
            end
        end
        if (rvalid_r && s_axi_rready_i) begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
        fifo_wp_nxt = fifo_wp_r + {{FIFO_AW{1'b0}}, end_address_valid_pulse_r};
        fifo_rp_nxt = fifo_rp_r + {{FIFO_AW{1'b0}}, end_address_fifo_pop};
        // New events win over a clear in the same cycle
        irq_stat_nxt = irq_stat_r;
        if (do_wr && aw_addr_r == `RXHF_OFS_IRQ_CLR) begin
            irq_stat_nxt = irq_stat_r & ~(w_data_r[2:0] & {3{w_strb_r[0]}});
        end
        irq_stat_nxt[`RXHF_IRQ_ACCEPT]   = irq_stat_nxt[`RXHF_IRQ_ACCEPT] | accept;
        irq_stat_nxt[`RXHF_IRQ_REJECT]   = irq_stat_nxt[`RXHF_IRQ_REJECT]
                                           | (pkt_end && !(&flags_upd));
        irq_stat_nxt[`RXHF_IRQ_OVERFLOW] = irq_stat_nxt[`RXHF_IRQ_OVERFLOW]
                                           | (pkt_end && (&flags_upd) && !accept);
        irq_nxt = |(irq_stat_nxt & irq_en_nxt);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            aw_got_r                   <= 1'b0;
            w_got_r                    <= 1'b0;
            aw_addr_r                  <= 8'h0;
            w_data_r                   <= 32'h0;
            w_strb_r                   <= 4'h0;
            bvalid_r                   <= 1'b0;
            bresp_r                    <= `RXHF_RESP_OKAY;
            rvalid_r                   <= 1'b0;
            rresp_r                    <= `RXHF_RESP_OKAY;
            rdata_r                    <= 32'h0;
            arready_r                  <= 1'b1;
            header_byte_compare_mask_r <= `RXHF_RST_MASK;
            expected_header_value_r    <= 320'h0;
            rx_ram_read_address_r      <= '0;
            end_address_fifo_word_r    <= '0;
            fifo_wp_r                  <= '0;
            fifo_rp_r                  <= '0;
            irq_stat_r                 <= 3'h0;
            irq_en_r                   <= `RXHF_RST_IRQ_EN;
            irq_r                      <= 1'b0;
        end else begin
            aw_got_r                   <= aw_got_nxt;
            w_got_r                    <= w_got_nxt;
            aw_addr_r                  <= aw_addr_nxt;
            w_data_r                   <= w_data_nxt;
            w_strb_r                   <= w_strb_nxt;
            bvalid_r                   <= bvalid_nxt;
            bresp_r                    <= bresp_nxt;
            rvalid_r                   <= rvalid_nxt;
            rresp_r                    <= rresp_nxt;
            rdata_r                    <= rdata_nxt;
            arready_r                  <= arready_nxt;
            header_byte_compare_mask_r <= header_byte_compare_mask_nxt;
            expected_header_value_r    <= expected_header_value_nxt;
            rx_ram_read_address_r      <= rx_ram_read_address_nxt;
            end_address_fifo_word_r    <= end_address_fifo_word_nxt;
            fifo_wp_r                  <= fifo_wp_nxt;
            fifo_rp_r                  <= fifo_rp_nxt;
            irq_stat_r                 <= irq_stat_nxt;
            irq_en_r                   <= irq_en_nxt;
            irq_r                      <= irq_nxt;
        end
    end

    // AW and W ready flags are the inverse of the hold flags, so they come from flip-flops too
    assign s_axi_awready_o = !aw_got_r;
    assign s_axi_wready_o  = !w_got_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rdata_o   = rdata_r;
    assign irq_o           = irq_r;
endmodule : rxhf_top
`default_nettype wire

// ===== rxhf_top_assertions.sv
// Bus handshake checker for the receive header filter
`timescale 1ns/1ps
`default_nettype none
module rxhf_top_assertions (
    input wire logic        clk_sys_i,
    input wire logic        rstn_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rready_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence wr_both;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence b_done;
        s_axi_bvalid_o && s_axi_bready_i;
    endsequence
    a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
        && $stable(s_axi_bresp_o)) else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o)) else $error("read data dropped early");
    a_aw_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while data pending");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_write_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid_o)
        else $error("write answer late");
    a_b_release: assert property (b_done |=> !s_axi_bvalid_o && s_axi_awready_o)
        else $error("write response not released");
    a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read data not released");
endmodule : rxhf_top_assertions
bind rxhf_top rxhf_top_assertions u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rready_i(s_axi_rready_i));
`default_nettype wire

// ===== rxhf_mac_model.sv
// Receive stream source standing in for the MAC
`timescale 1ns/1ps
`default_nettype none
module rxhf_mac_model (
    input  wire logic                clk_sys_i,
    output var rxhf_pkg::rxhf_beat_t beat_o
);
    initial beat_o = '0;
    // Beat i carries tag in the high half and b0 plus i in byte 0
    task automatic send(input logic [31:0] tag, input logic [7:0] b0, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            beat_o <= '{1'h1, (i == n - 1), {tag, 24'h0, b0 + 8'(i)}};
        end
        @(posedge clk_sys_i);
        // Idle data is scrambled so a stale beat cannot pass for fresh
        beat_o <= '{1'h0, 1'h0, ~beat_o.data};
    endtask : send
endmodule : rxhf_mac_model
`default_nettype wire

// ===== rxhf_top_bench.sv
// Self-checking bench for the receive header filter
`timescale 1ns/1ps
`default_nettype none
module rxhf_top_bench;
    logic clk_sys_i = 1'h0, rstn_i = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
    logic arv = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    wire rxhf_pkg::rxhf_beat_t beat;
    int errors = 0, checks = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    rxhf_mac_model u_mac (.clk_sys_i(clk_sys_i), .beat_o(beat));
    rxhf_top u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mac_rx_beat_i(beat),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq));
    task tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task bound(input int n);
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
    endtask : bound
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a; wdata <= d; awv <= 1'h1; wv <= 1'h1; bready <= 1'h1;
        do begin
            @(posedge clk_sys_i); n++;
            if (awready) awv <= 1'h0;
            if (wready) wv <= 1'h0;
        end while (!bvalid && n < 50);
        bready <= 1'h0; bound(n);
        chk("bresp", 32'h0, {30'h0, bresp});
        // Idle edge so back-to-back calls never reassign a strobe in one step
        @(posedge clk_sys_i);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a; arv <= 1'h1; rready <= 1'h1;
        do begin
            @(posedge clk_sys_i); n++;
            if (arready) arv <= 1'h0;
        end while (!rvalid && n < 50);
        rready <= 1'h0; bound(n);
        chk($sformatf("data at %h", a), e, rdata);
        chk($sformatf("resp at %h", a), {30'h0, er}, {30'h0, rresp});
        @(posedge clk_sys_i);
    endtask : rd
    // -------------------------------------------------------------
    // Accept, reject and overwrite sequence
    // -------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'h1;
        rd(8'h00, 32'h0, 2'h0); rd(8'h1C, 32'h0, 2'h0);
        rd(8'hFC, 32'h0, 2'h2);
        wr(8'h40, 32'hA5); wr(8'h20, 32'h1); wr(8'h1C, 32'h1);
        u_mac.send(32'hAAAA0001, 8'hA5, 6);
        rd(8'h28, 32'h6, 2'h0); chk("irq", 32'h1, {31'h0, irq});
        rd(8'h00, 32'h1, 2'h0);
        wr(8'h04, 32'h0); rd(8'h08, 32'h6, 2'h0);
        // Last 32-bit word of a six-beat packet sits at index eleven
        wr(8'h0C, 32'hB); rd(8'h10, 32'hAAAA0001, 2'h0);
        wr(8'h0C, 32'h0); rd(8'h10, 32'hA5, 2'h0);
        u_mac.send(32'hBBBB0002, 8'h00, 4);
        rd(8'h28, 32'h6, 2'h0); rd(8'h00, 32'h0, 2'h0);
        rd(8'h14, 32'h3, 2'h0);
        wr(8'h4C, 32'h06450008); wr(8'h54, 32'h06450008);
        wr(8'h5C, 32'h06450008); wr(8'h60, 32'h5E); wr(8'h24, 32'h3);
        wr(8'h20, 32'hFC807000); u_mac.send(32'h06450008, 8'h5A, 5);
        rd(8'h28, 32'hB, 2'h0); rd(8'h00, 32'h1, 2'h0);
        wr(8'h0C, 32'hC); rd(8'h10, 32'h5A, 2'h0);
        wr(8'h18, 32'h7); rd(8'h14, 32'h0, 2'h0);
        chk("irq", 32'h0, {31'h0, irq});
        tally_and_finish();
    end
endmodule : rxhf_top_bench
`default_nettype wire
